// >>> ci_units_regs.vh
// Purpose: constants for the custom instruction extension units
// Assumes: 8-bit opcode extension field from the processor
// Notes:   floating-point latencies are implementation choices
`ifndef CI_UNITS_REGS_VH
`define CI_UNITS_REGS_VH
`define CI_OP_FP_MUL   8'hFC
`define CI_OP_FP_ADD   8'hFD
`define CI_OP_FP_SUB   8'hFE
`define CI_OP_FP_DIV   8'hFF
`define CI_OP_BYTEREV  8'h00
`define CI_OP_BITREV   8'h01
`define CI_FP_LAT      2'd2
`define CI_DIV_STEPS   5'd25
`define CI_QNAN        32'h7FC0_0000
`endif

// >>> custom_instruction_units.v
// Purpose: fixed-function extension units on the custom-instruction port
// Assumes: start is a one-cycle pulse; processor holds operands until done
// Notes:   results truncate, denormals flush to zero, no NaN propagation
`include "ci_units_regs.vh"
module custom_instruction_units #(
  parameter USE_DIV = 0
) (
  input  wire        clock,
  input  wire        arst_n,
  input  wire        start,
  input  wire [7:0]  opx,
  input  wire [31:0] dataa,
  input  wire [31:0] datab,
  output wire        done,
  output wire        busy,
  output wire [31:0] result
);
  // No interrupt-vector unit here, so the one-per-core limit holds
  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_DIV  = 2'd2;

  // Upper six bits all set selects the four fixed float extensions
  function is_fp;
    input [7:0] op;
    begin
      is_fp = (op[7:2] == 6'b111111);
    end
  endfunction

  reg [1:0]  state_ff;
  reg [1:0]  cnt_ff;
  reg [4:0]  dcnt_ff;
  reg        done_ff;
  reg [31:0] result_ff;
  reg [31:0] fres_ff;
  // Divider working state
  reg [24:0] rem_ff;
  reg [25:0] quo_ff;
  reg        dsign_ff;
  reg [9:0]  dexp_ff;

  wire [31:0] byterev = {dataa[7:0], dataa[15:8], dataa[23:16], dataa[31:24]};
  wire [31:0] bitrev;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_rev
      assign bitrev[gi] = dataa[31-gi];
    end
  endgenerate

  // Operand fields
  wire        sa = dataa[31];
  wire        sb = datab[31] ^ (opx == `CI_OP_FP_SUB);
  wire [7:0]  ea = dataa[30:23];
  wire [7:0]  eb = datab[30:23];
  wire [23:0] ma = (ea == 8'h00) ? 24'h00_0000 : {1'b1, dataa[22:0]};
  wire [23:0] mb = (eb == 8'h00) ? 24'h00_0000 : {1'b1, datab[22:0]};

  // Multiply: plain product lets synthesis pick hard multipliers or logic
  wire [47:0] prod = ma * mb;
  wire [9:0]  pexp = {2'b00, ea} + {2'b00, eb} - 10'd127 + {9'd0, prod[47]};
  wire [22:0] pman = prod[47] ? prod[46:24] : prod[45:23];
  reg  [31:0] mul_res;
  always @* begin
    // Zero exponent would be a denormal, so flush it
    if (ma == 24'h00_0000 || mb == 24'h00_0000 || pexp[9] || pexp == 10'd0)
      mul_res = {sa ^ datab[31], 31'h0000_0000};
    else if (pexp[8] || pexp[7:0] == 8'hFF)
      mul_res = {sa ^ datab[31], 8'hFF, 23'h00_0000};
    else
      mul_res = {sa ^ datab[31], pexp[7:0], pman};
  end

  // Add/subtract with alignment and leading-zero normalise
  wire        swap = {ea, ma} < {eb, mb};
  wire [7:0]  eh = swap ? eb : ea;
  wire [7:0]  ediff = swap ? (eb - ea) : (ea - eb);
  wire [23:0] mh = swap ? mb : ma;
  wire [23:0] ml = swap ? ma : mb;
  wire        sh = swap ? sb : sa;
  // Shifts past the mantissa width are forced to zero; no rounding
  wire [24:0] mls = (ediff > 8'd24) ? 25'd0 : ({1'b0, ml} >> ediff);
  wire [24:0] msum = (sa == sb) ? ({1'b0, mh} + mls) : ({1'b0, mh} - mls);
  reg  [4:0]  lz;
  reg  [31:0] add_res;
  reg  [24:0] nm;
  reg  [9:0]  ne;
  integer     k;
  always @* begin
    // Highest set bit is found last, so lz counts from the top one
    lz = 5'd24;
    for (k = 0; k < 24; k = k + 1)
      if (msum[k])
        lz = 5'd23 - k[4:0];
    nm = 25'd0;
    ne = 10'd0;
    if (msum == 25'd0) begin
      add_res = 32'h0000_0000;
    end else if (msum[24]) begin
      ne = {2'b00, eh} + 10'd1;
      add_res = (ne >= 10'd255) ? {sh, 8'hFF, 23'h00_0000} : {sh, ne[7:0], msum[23:1]};
    end else begin
      nm = msum << lz;
      ne = {2'b00, eh} - {5'd0, lz};
      add_res = (ne[9] || ne == 10'd0) ? {sh, 31'h0000_0000} : {sh, ne[7:0], nm[22:0]};
    end
  end

  // Restoring divide, one quotient bit per cycle
  // Divisor is read on every step, so operands must hold until done
  wire [24:0] rsub = rem_ff - {1'b0, mb};
  wire        do_div = (USE_DIV != 0) && (opx == `CI_OP_FP_DIV);
  // The last bit arrives on the edge that loads the result, so build it
  // from the next quotient rather than the stored one
  wire        qbit    = (rem_ff >= {1'b0, mb});
  wire [25:0] nxt_quo = {quo_ff[24:0], qbit};
  wire [9:0]  qexp = nxt_quo[25] ? dexp_ff : dexp_ff - 10'd1;
  wire [22:0] qman = nxt_quo[25] ? nxt_quo[24:2] : nxt_quo[23:1];
  reg  [31:0] div_res;
  always @* begin
    if (qexp[9] || qexp == 10'd0)
      div_res = {dsign_ff, 31'h0000_0000};
    else if (qexp[8] || qexp[7:0] == 8'hFF)
      div_res = {dsign_ff, 8'hFF, 23'h00_0000};
    else
      div_res = {dsign_ff, qexp[7:0], qman};
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff  <= S_IDLE;
      cnt_ff    <= 2'd0;
      dcnt_ff   <= 5'd0;
      done_ff   <= 1'b0;
      result_ff <= 32'h0000_0000;
      fres_ff   <= 32'h0000_0000;
      rem_ff    <= 25'd0;
      quo_ff    <= 26'd0;
      dsign_ff  <= 1'b0;
      dexp_ff   <= 10'd0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (start) begin
            // One-cycle units share the result register with the float path
            if (!is_fp(opx)) begin
              done_ff   <= 1'b1;
              result_ff <= (opx == `CI_OP_BITREV) ? bitrev : byterev;
            end else if (opx == `CI_OP_FP_DIV && !do_div) begin
              // Divide not built: answer at once with a quiet NaN
              done_ff   <= 1'b1;
              result_ff <= `CI_QNAN;
            end else if (do_div) begin
              // Zero divisor gives signed infinity, else a zero dividend gives signed zero
              if (mb == 24'h00_0000 || ma == 24'h00_0000) begin
                done_ff   <= 1'b1;
                result_ff <= (mb == 24'h00_0000) ? {sa ^ datab[31], 8'hFF, 23'h00_0000}
                                                 : {sa ^ datab[31], 31'h0000_0000};
              end else begin
                state_ff <= S_DIV;
                dcnt_ff  <= `CI_DIV_STEPS;
                rem_ff   <= {1'b0, ma};
                quo_ff   <= 26'd0;
                dsign_ff <= sa ^ datab[31];
                dexp_ff  <= {2'b00, ea} - {2'b00, eb} + 10'd127;
              end
            end else begin
              state_ff <= S_WAIT;
              cnt_ff   <= `CI_FP_LAT;
              fres_ff  <= (opx == `CI_OP_FP_MUL) ? mul_res : add_res;
            end
          end
        end
        S_WAIT: begin
          // Fixed latency only delays fres_ff, which the datapath fills in the start cycle
          if (cnt_ff == 2'd1) begin
            state_ff  <= S_IDLE;
            done_ff   <= 1'b1;
            result_ff <= fres_ff;
          end
          cnt_ff <= cnt_ff - 2'd1;
        end
        S_DIV: begin
          if (rem_ff >= {1'b0, mb}) begin
            rem_ff <= {rsub[23:0], 1'b0};
            quo_ff <= {quo_ff[24:0], 1'b1};
          end else begin
            rem_ff <= {rem_ff[23:0], 1'b0};
            quo_ff <= {quo_ff[24:0], 1'b0};
          end
          // Counter wraps after the last step; leaving the state hides it
          dcnt_ff <= dcnt_ff - 5'd1;
          if (dcnt_ff == 5'd0) begin
            state_ff  <= S_IDLE;
            done_ff   <= 1'b1;
            result_ff <= div_res;
          end
        end
        // Unused state code falls back to idle
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Busy comes straight from the state so a stall shows without delay
  // Result holds the last answer until the next done
  assign done   = done_ff;
  assign busy   = (state_ff != S_IDLE);
  assign result = result_ff;
endmodule // custom_instruction_units

// >>> ci_units_props.sv
// Purpose: port checks for the extension units
// Assumes: latencies as handed over, divide unit not built by default
// Notes:   FP results are not checked here, only timing and the absent-divide NaN
`include "ci_units_regs.vh"
module ci_units_props #(parameter USE_DIV = 0) (
  input logic        clock,
  input logic        arst_n,
  input logic        start,
  input logic [7:0]  opx,
  input logic [31:0] dataa,
  input logic [31:0] datab,
  input logic        done,
  input logic        busy,
  input logic [31:0] result
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [31:0] byte_order(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  function automatic logic [31:0] bit_mirror(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = v[31 - i];
    return r;
  endfunction
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire take = start && !busy;
  sequence s_fp; ##1 busy [*2] ##1 (done && !busy); endsequence
  property p_byte; take && opx == 8'h00 |=> done && result == byte_order($past(dataa));
  endproperty
  a_byte: assert property (p_byte) else $error("byte swap wrong");
  property p_bit; take && opx == 8'h01 |=> done && result == bit_mirror($past(dataa));
  endproperty
  a_bit: assert property (p_bit) else $error("bit mirror wrong");
  property p_fp; take && opx inside {[8'hFC:8'hFE]} |-> s_fp; endproperty
  a_fp: assert property (p_fp) else $error("fp timing wrong");
  property p_one; take && opx inside {[8'h02:8'hFB]} |=> done && result == byte_order($past(dataa));
  endproperty
  a_one: assert property (p_one) else $error("non fp code misused");
  property p_nodiv; take && opx == 8'hFF && USE_DIV == 0 |=> done && result == `CI_QNAN;
  endproperty
  a_nodiv: assert property (p_nodiv) else $error("absent divide answered");
  property p_excl; done |-> !busy; endproperty
  a_excl: assert property (p_excl) else $error("done while busy");
  property p_hold; !done |-> $stable(result); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_bound; busy |-> ##[1:26] done; endproperty
  a_bound: assert property (p_bound) else $error("busy too long");
endmodule // ci_units_props
bind custom_instruction_units ci_units_props #(.USE_DIV(USE_DIV)) i_props (.clock(clock),
  .arst_n(arst_n), .start(start), .opx(opx), .dataa(dataa), .datab(datab), .done(done),
  .busy(busy), .result(result));

// >>> ci_host_model.sv
// Purpose: processor side of the custom-instruction port
// Assumes: bench raises issue for each request
// Notes:   operands move only with a new request
module ci_host_model (
  input  wire logic        clock,
  input  wire logic        issue,
  input  wire logic [7:0]  k,
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic             start,
  output logic [7:0]       opx,
  output logic [31:0]      dataa,
  output logic [31:0]      datab
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {start, opx, dataa, datab} = '0;
  always @(negedge clock) begin
    start <= issue;
    if (issue) {opx, dataa, datab} <= {k, a, b};
  end
endmodule // ci_host_model

// >>> tb_top.sv
// Purpose: self-checking bench for the extension units
// Assumes: divide unit left out
// Notes:   results matched in issue order
`include "ci_units_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, arst_n = 0, issue = 0, start, done, busy;
  logic [7:0]  k = 0, opx;
  logic [31:0] a = 0, b = 0, seed = 32'h0000_0013, dataa, datab, result;
  logic [31:0] q[$];
  int          mismatches = 0, total_checks = 0;
  ci_host_model i_ci_host_model (.clock(clock), .issue(issue), .k(k), .a(a), .b(b),
    .start(start), .opx(opx), .dataa(dataa), .datab(datab));
  custom_instruction_units i_custom_instruction_units (.clock(clock), .arst_n(arst_n),
    .start(start), .opx(opx), .dataa(dataa), .datab(datab), .done(done), .busy(busy),
    .result(result));
  initial forever #2.5 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] swap(input logic [7:0] op, input logic [31:0] v);
    logic [31:0] r;
    r = {v[7:0], v[15:8], v[23:16], v[31:24]};
    if (op == 8'h01) begin
      for (int i = 0; i < 32; i++) r[i] = v[31 - i];
    end
    return r;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(input logic [7:0] op, input logic [31:0] x, y, want);
    @(posedge clock);
    issue <= 1; k <= op; a <= x; b <= y;
    q.push_back(want);
  endtask
  task automatic drain();
    @(posedge clock);
    issue <= 0;
    for (int n = 0; n < 60 && q.size() > 0; n++) @(negedge clock);
    if (q.size() > 0) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  always @(negedge clock) begin
    if (done === 1'b1) begin
      // Extra done with nothing queued fails against the inverse
      check(result, q.size() ? q.pop_front() : ~result);
    end
  end
  initial begin
    logic [7:0]  op;
    logic [31:0] x;
    repeat (3) @(negedge clock);
    arst_n = 1;
    for (int i = 0; i < 60; i++) begin
      x = rnd();
      op = i < 3 ? 8'hFB - 8'(i * 125) : 8'(x[15:8] % 252);
      send(op, x, rnd(), swap(op, x));
    end
    // Swapping twice gives the word back
    send(8'h00, 32'h1122_3344, 32'h0000_0000, 32'h4433_2211);
    send(8'h00, 32'h4433_2211, 32'h0000_0000, 32'h1122_3344);
    drain();
    // Second start while busy must be ignored
    send(`CI_OP_FP_ADD, 32'h3FC0_0000, 32'h4010_0000, 32'h4070_0000);
    @(posedge clock);
    @(negedge clock);
    check({31'h0000_0000, busy}, 32'h0000_0001);
    drain();
    send(`CI_OP_FP_SUB, 32'h4070_0000, 32'h3FC0_0000, 32'h4010_0000);
    drain();
    send(`CI_OP_FP_MUL, 32'h4040_0000, 32'h3F00_0000, 32'h3FC0_0000);
    drain();
    send(`CI_OP_FP_DIV, 32'h40C0_0000, 32'h4040_0000, `CI_QNAN);
    drain();
    tally_and_finish();
  end
endmodule // tb_top
